/* src/fpt_pkg.sv */
package fpt_pkg;
    // Relative byte offsets of the two descriptor words
    localparam logic [7:0] FPT_W11_BASE = 8'h28;
    localparam logic [7:0] FPT_W12_BASE = 8'h2C;
    localparam logic [7:0] FPT_W12_LAST = 8'h2F;

    // First descriptor word fields
    localparam logic [0:0] FPT_ADD_UNIT = 1'h0;
    localparam logic [3:0] FPT_ADD_CNT = 4'h0;
    localparam logic [0:0] FPT_FIRST_UNIT = 1'h1;
    localparam logic [3:0] FPT_FIRST_CNT = 4'hC;
    localparam logic [0:0] FPT_PAGE_UNIT = 1'h1;
    localparam logic [4:0] FPT_PAGE_CNT = 5'h05;
    localparam logic [3:0] FPT_PAGE_EXP = 4'h9;
    localparam logic [3:0] FPT_PGM_MULT = 4'h1;
    // Upper byte belongs to the chip-erase fields of the same word
    localparam logic [7:0] FPT_W11_TOP = 8'hD9;

    // Second descriptor word fields
    localparam logic [0:0] FPT_SUSP_NOT_SUP = 1'h0;
    localparam logic [1:0] FPT_ERS_SUSP_UNIT = 2'h2;
    localparam logic [4:0] FPT_ERS_SUSP_CNT = 5'h05;
    localparam logic [3:0] FPT_ERS_RES_CNT = 4'h1;
    localparam logic [1:0] FPT_PGM_SUSP_UNIT = 2'h2;
    localparam logic [4:0] FPT_PGM_SUSP_CNT = 5'h04;
    localparam logic [3:0] FPT_PGM_RES_CNT = 4'h1;
    localparam logic [0:0] FPT_W12_RSVD = 1'h1;
    localparam logic [3:0] FPT_ERS_PROHIB = 4'hE;
    localparam logic [3:0] FPT_PGM_PROHIB = 4'hC;

    // Expected assembled words
    localparam logic [31:0] FPT_W11_WORD = 32'hD9072591;
    localparam logic [31:0] FPT_W12_WORD = 32'h451883EC;

    // Reset value of data output
    localparam logic [7:0] FPT_DATA_RST = 8'h00;
endpackage

/* src/fpt_byte_sel.sv */
`timescale 1ns/100ps
module fpt_byte_sel (
    input wire logic [31:0] word_i,
    input wire logic [1:0] lane_i,
    output logic [7:0] byte_o
);
    // Little-endian lanes: lane 0 is the lowest offset
    always_comb begin
        byte_o = word_i[8*lane_i +: 8];
    end
endmodule

/* src/fpt_table.sv */
`timescale 1ns/100ps
module fpt_table
    import fpt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rd_req_i,
    input wire logic [7:0] rd_off_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic rd_hit_o
);

////////////////////////////////////////////////////////////////////////////////

    logic [31:0] word11;
    logic [31:0] word12;

    // Fields assembled from named constants so each value is checked once
    assign word11 = {FPT_W11_TOP,
                     FPT_ADD_UNIT,
                     FPT_ADD_CNT,
                     FPT_FIRST_UNIT,
                     FPT_FIRST_CNT,
                     FPT_PAGE_UNIT,
                     FPT_PAGE_CNT,
                     FPT_PAGE_EXP,
                     FPT_PGM_MULT};

    assign word12 = {FPT_SUSP_NOT_SUP,
                     FPT_ERS_SUSP_UNIT, FPT_ERS_SUSP_CNT,
                     FPT_ERS_RES_CNT,
                     FPT_PGM_SUSP_UNIT, FPT_PGM_SUSP_CNT,
                     FPT_PGM_RES_CNT,
                     FPT_W12_RSVD,
                     FPT_ERS_PROHIB,
                     FPT_PGM_PROHIB};

////////////////////////////////////////////////////////////////////////////////

    logic in_w11;
    logic in_w12;
    logic [31:0] sel_word;
    logic [7:0] sel_byte;

    assign in_w11 = (rd_off_i >= FPT_W11_BASE) && (rd_off_i < FPT_W12_BASE);
    assign in_w12 = (rd_off_i >= FPT_W12_BASE) && (rd_off_i <= FPT_W12_LAST);
    assign sel_word = in_w12 ? word12 : word11;

    fpt_byte_sel u_sel (
        .word_i(sel_word),
        .lane_i(rd_off_i[1:0]),
        .byte_o(sel_byte)
    );

////////////////////////////////////////////////////////////////////////////////

    logic rd_valid_r, rd_valid_nxt;
    logic rd_hit_r, rd_hit_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;

    // Offsets outside the two words read as zero, flagged by a low hit
    always_comb begin
        rd_valid_nxt = rd_req_i;
        rd_hit_nxt = rd_hit_r;
        rd_data_nxt = rd_data_r;
        if (rd_req_i) begin
            rd_hit_nxt = in_w11 | in_w12;
            rd_data_nxt = (in_w11 | in_w12) ? sel_byte : FPT_DATA_RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_valid_r <= 1'b0;
            rd_hit_r <= 1'b0;
            rd_data_r <= FPT_DATA_RST;
        end else begin
            rd_valid_r <= rd_valid_nxt;
            rd_hit_r <= rd_hit_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_valid_o = rd_valid_r;
    assign rd_data_o = rd_data_r;
    assign rd_hit_o = rd_hit_r;

////////////////////////////////////////////////////////////////////////////////

    chk_word11_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        word11 == FPT_W11_WORD) else $error("word one value wrong");
    chk_word12_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        word12 == FPT_W12_WORD) else $error("word two value wrong");
    chk_off_2b_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2B |=> rd_valid_o && rd_data_o == 8'hD9)
        else $error("offset 2Bh byte wrong");
    chk_off_2a_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2A |=> rd_data_o == 8'h07)
        else $error("offset 2Ah byte wrong");
    chk_off_2c_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2C |=> rd_data_o == 8'hEC && rd_hit_o)
        else $error("offset 2Ch byte wrong");
    chk_off_2f_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2F |=> rd_data_o == 8'h45)
        else $error("offset 2Fh byte wrong");
    chk_suspend_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2F |=> !rd_data_o[7]) else $error("suspend bit set");
    chk_rsvd_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2D |=> rd_data_o[0]) else $error("reserved bit low");
    chk_read_pairs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i ##1 rd_req_i |-> rd_valid_o [*2]) else $error("read valid lost");
    chk_miss_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && !(in_w11 || in_w12) |=> !rd_hit_o && rd_data_o == 8'h00)
        else $error("miss data not zero");
    chk_off_28_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h28 |=> rd_data_o == 8'h91)
        else $error("offset 28h byte wrong");
    chk_off_29_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h29 |=> rd_data_o == 8'h25)
        else $error("offset 29h byte wrong");
    chk_off_2d_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2D |=> rd_data_o == 8'h83)
        else $error("offset 2Dh byte wrong");
    chk_off_2e_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && rd_off_i == 8'h2E |=> rd_data_o == 8'h18)
        else $error("offset 2Eh byte wrong");
    chk_hit_in_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && (in_w11 || in_w12) |=> rd_valid_o && rd_hit_o)
        else $error("table hit lost");
    chk_idle_no_valid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_req_i |=> !rd_valid_o) else $error("valid without request");
    // Host may collect the byte late, so it must not move without a request
    chk_idle_data_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_req_i |=> $stable(rd_data_o) && $stable(rd_hit_o))
        else $error("held byte changed");

    cov_read_w11: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && in_w11);
    cov_read_w12: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && in_w12);
    cov_read_miss: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i && !(in_w11 || in_w12));
    cov_back_to_back: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_req_i ##1 rd_req_i ##1 rd_req_i);
endmodule

/* sim/fpt_host_model.sv */
`timescale 1ns/100ps
module fpt_host_model (
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_hit_i,
    output logic rd_req_o,
    output logic [7:0] rd_off_o
);
    // Table reads only, never suspends, resumes, erases or programs
    initial begin
        rd_req_o = 1'b0;
        rd_off_o = 8'h00;
    end
    // Back to back requests; each answer is collected one cycle behind
    task automatic read_burst(input logic [7:0] base, input int n,
            output logic [63:0] data, output logic [7:0] hits, output int nv);
        data = '0;
        hits = '0;
        nv = 0;
        for (int j = 0; j <= n; j++) begin
            @(posedge clk_i);
            rd_req_o <= (j < n);
            rd_off_o <= base + 8'(j);
            #1;
            if (j > 0 && rd_valid_i === 1'b1) begin
                nv++;
                data[8*(j-1) +: 8] = rd_data_i;
                hits[j-1] = rd_hit_i;
            end
        end
    endtask
endmodule

/* sim/fpt_table_bench.sv */
`timescale 1ns/100ps
module fpt_table_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rd_req_i;
    logic rd_valid_o;
    logic rd_hit_o;
    logic [7:0] rd_off_i;
    logic [7:0] rd_data_o;
    logic [63:0] d;
    logic [7:0] hits;
    int nv;
    int n_fail = 0;
    int n_compared = 0;
    always #50 clk_i = ~clk_i;
    fpt_table DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_req_i(rd_req_i),
        .rd_off_i(rd_off_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .rd_hit_o(rd_hit_o));
    fpt_host_model host (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .rd_hit_i(rd_hit_o), .rd_req_o(rd_req_i), .rd_off_o(rd_off_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Also checks one valid per request, that valid drops after the burst and that the last byte holds
    task automatic burst(input logic [7:0] base, input int n, input logic [63:0] ed,
            input logic [7:0] eh);
        host.read_burst(base, n, d, hits, nv);
        chk(64'(nv), 64'(n));
        chk(d, ed);
        chk(64'(hits), 64'(eh));
        @(posedge clk_i);
        #1;
        chk({55'h0, rd_valid_o, rd_data_o}, {56'h0, ed[8*(n-1) +: 8]});
        $display("test at %h done", base);
    endtask
    task automatic test_done;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        n_fail++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #1 chk(64'({rd_valid_o, rd_hit_o, rd_data_o}), 64'h0);
        @(posedge clk_i) rst_n_i <= 1'b1;
        burst(8'h28, 8, 64'h451883EC_D9072591, 8'hFF);
        chk(64'(d[23]), 64'h0);
        chk(64'(d[22:19]), 64'h0);
        chk(64'(d[18]), 64'h1);
        chk(64'(d[17:14]), 64'hC);
        chk(64'(d[13]), 64'h1);
        chk(64'(d[12:8]), 64'h05);
        chk(64'(d[7:4]), 64'h9);
        chk(64'(d[3:0]), 64'h1);
        chk(64'(d[63]), 64'h0);
        chk(64'(d[62:56]), 64'h45);
        chk(64'(d[55:52]), 64'h1);
        chk(64'(d[51:45]), 64'h44);
        chk(64'(d[44:41]), 64'h1);
        chk(64'(d[40]), 64'h1);
        chk(64'(d[39:36]), 64'hE);
        chk(64'(d[35:32]), 64'hC);
        $display("test fields done");
        burst(8'h26, 2, 64'h0, 8'h00);
        burst(8'h30, 1, 64'h0, 8'h00);
        burst(8'h2B, 1, 64'hD9, 8'h01);
        // Reset mid-run must clear a held byte, then the table is unchanged
        @(posedge clk_i) rst_n_i <= 1'b0;
        @(posedge clk_i);
        #1 chk(64'({rd_valid_o, rd_hit_o, rd_data_o}), 64'h0);
        @(posedge clk_i) rst_n_i <= 1'b1;
        burst(8'h2C, 4, 64'h451883EC, 8'h0F);
        test_done();
    end
endmodule
